// [tpm_pkg.sv]
/*
  Package for the pulse measurement timer channel: register offsets,
  field positions, reset values and shared types.
  Assumes a 32-bit AHB-Lite register bus, one word per register.
*/
package tpm_pkg;
  // Register byte offsets
  localparam logic [7:0] TPM_OFS_CTRL = 8'h00;
  localparam logic [7:0] TPM_OFS_MODE = 8'h04;
  localparam logic [7:0] TPM_OFS_TIMER = 8'h08;
  localparam logic [7:0] TPM_OFS_STAT = 8'h0C;
  localparam logic [7:0] TPM_OFS_MASK = 8'h10;
  localparam logic [7:0] TPM_OFS_COUNT = 8'h14;
  // Control fields
  localparam int TPM_CTRL_START = 0;
  // Mode fields
  localparam int TPM_MODE_FUNC = 0;
  localparam int TPM_MODE_BIT_TWO = 2;
  localparam int TPM_MODE_BIT_THREE = 3;
  localparam int TPM_MODE_EVSEL = 5;
  localparam int TPM_MODE_CLK_LO = 6;
  localparam int TPM_MODE_CLK_HI = 7;
  // Status fields
  localparam int TPM_STAT_EDGE = 0;
  localparam int TPM_STAT_OVF = 1;
  localparam int TPM_STAT_OVFLAG = 2;
  // Reset values and counter maximum
  localparam logic [7:0] TPM_MODE_RST = 8'h00;
  localparam logic [15:0] TPM_COUNT_RST = 16'h0000;
  localparam logic [15:0] TPM_COUNT_MAX = 16'hFFFF;
  // Prescaler divisors as terminal counts
  localparam logic [4:0] TPM_DIV8_LAST = 5'h07;
  localparam logic [4:0] TPM_DIV32_LAST = 5'h1F;
  // Channel index of this instance
  localparam int TPM_CHANNEL = 0;

  // Measurement function selected by mode bits 1:0
  typedef enum logic [1:0]
  {
    TPM_FN_PERIOD = 2'b00,
    TPM_FN_WIDTH = 2'b01,
    TPM_FN_EVENT = 2'b10,
    TPM_FN_RSVD = 2'b11
  } tpm_func_e;

  // Bus request after the address phase
  typedef struct packed
  {
    logic valid;
    logic write;
    logic [7:0] addr;
  } tpm_req_s;

  // Events from the measuring core
  typedef struct packed
  {
    logic edge_irq;
    logic ovf;
  } tpm_evt_s;
endpackage : tpm_pkg

// [tpm_tick.sv]
/*
  Count clock prescaler: one-cycle ticks at f1, f8, f32 and fC32.
  Assumes fC32 arrives as a synchronous level and is edge detected here.
*/
`timescale 1ns/10ps
`default_nettype none
module tpm_tick
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Selection
  input wire logic [1:0] sel_i,
  input wire logic fc32_i,
  // Tick out
  output logic tick_o
);
  logic [4:0] div;
  logic [4:0] next_div;
  logic fc_d;
  logic next_fc_d;
  logic next_tick;

  // Free running divider and sub clock edge detect
  always_comb
  begin
    next_div = div + 5'h01;
    next_fc_d = fc32_i;
    case (sel_i)
      2'b00: next_tick = 1'b1;
      2'b01: next_tick = (div[2:0] == tpm_pkg::TPM_DIV8_LAST[2:0]);
      2'b10: next_tick = (div == tpm_pkg::TPM_DIV32_LAST);
      default: next_tick = fc32_i & ~fc_d;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      div <= 5'h00;
      fc_d <= 1'b0;
      tick_o <= 1'b0;
    end
    else
    begin
      div <= next_div;
      fc_d <= next_fc_d;
      tick_o <= next_tick;
    end
  end
endmodule : tpm_tick
`default_nettype wire

// [tpm_core.sv]
/*
  Pulse period / pulse width measurement timer channel with AHB-Lite
  registers and one masked level interrupt.
  Assumes the measure and neighbour inputs are synchronous to mclk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module tpm_core
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Pins and neighbour
  input wire logic measure_input_pin_i,
  input wire logic neighbour_channel_overflow_i,
  input wire logic fc32_i,
  // Interrupt
  input wire logic irq_ack_i,
  output logic irq_o,
  output logic overflow_o
);
  tpm_pkg::tpm_req_s req;
  tpm_pkg::tpm_req_s next_req;
  logic start;
  logic next_start;
  logic [7:0] mode;
  logic [7:0] next_mode;
  logic [15:0] count;
  logic [15:0] next_count;
  logic [15:0] reload;
  logic [15:0] next_reload;
  logic [2:0] stat;
  logic [2:0] next_stat;
  logic [2:0] mask;
  logic [2:0] next_mask;
  logic first_seen;
  logic next_first_seen;
  logic valid_res;
  logic next_valid_res;
  logic pin_d;
  logic next_pin_d;
  logic [31:0] next_rdata;
  logic next_irq;
  logic tick;
  logic rise;
  logic fall;
  logic eff_edge;
  logic ev_edge;
  logic cnt_step;
  logic wr;
  logic rd;
  tpm_pkg::tpm_evt_s evt;
  tpm_pkg::tpm_func_e func;

  // Address match of a registered request
  function automatic logic hit(input tpm_pkg::tpm_req_s r,
                               input logic [7:0] ofs);
    hit = r.valid && (r.addr == ofs);
  endfunction : hit

  tpm_tick i_tpm_tick
  (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .sel_i(mode[tpm_pkg::TPM_MODE_CLK_HI:tpm_pkg::TPM_MODE_CLK_LO]),
    .fc32_i(fc32_i),
    .tick_o(tick)
  );

  assign func = tpm_pkg::tpm_func_e'(mode[1:0]);
  assign rise = measure_input_pin_i & ~pin_d;
  assign fall = ~measure_input_pin_i & pin_d;
  assign wr = req.valid & req.write;
  assign rd = req.valid & ~req.write;

  // Effective edge decode per function
  always_comb
  begin
    eff_edge = 1'b0;
    ev_edge = 1'b0;
    case (func)
      tpm_pkg::TPM_FN_PERIOD: eff_edge = fall;
      tpm_pkg::TPM_FN_WIDTH: eff_edge = rise | fall;
      tpm_pkg::TPM_FN_EVENT:
      begin
        if (mode[tpm_pkg::TPM_MODE_EVSEL])
          ev_edge = neighbour_channel_overflow_i;
        // edge select only for the pin
        else if (mode[tpm_pkg::TPM_MODE_BIT_THREE])
          ev_edge = rise;
        else
          ev_edge = fall;
      end
      default:
      begin
        eff_edge = 1'b0;
        ev_edge = 1'b0;
      end
    endcase
  end

  assign cnt_step = (func == tpm_pkg::TPM_FN_EVENT) ? ev_edge : tick;

  // Bus address phase capture; always zero wait, always OKAY
  always_comb
  begin
    next_req.valid = hsel_i & hready_i & htrans_i[1];
    next_req.write = hwrite_i;
    next_req.addr = haddr_i[7:0];
  end

  // Register and counter next values
  always_comb
  begin
    next_start = start;
    next_mode = mode;
    next_count = count;
    next_reload = reload;
    next_mask = mask;
    next_first_seen = first_seen;
    next_valid_res = valid_res;
    next_pin_d = measure_input_pin_i;
    evt.edge_irq = 1'b0;
    evt.ovf = 1'b0;
    if (wr && hit(req, tpm_pkg::TPM_OFS_CTRL))
    begin
      next_start = hwdata_i[tpm_pkg::TPM_CTRL_START];
      if (hwdata_i[tpm_pkg::TPM_CTRL_START] && !start)
      begin
        next_first_seen = 1'b0;
        next_valid_res = 1'b0;
      end
    end
    if (wr && hit(req, tpm_pkg::TPM_OFS_MODE))
    begin
      next_mode = hwdata_i[7:0];
      next_mode[tpm_pkg::TPM_MODE_BIT_TWO] = 1'b0;
    end
    if (wr && hit(req, tpm_pkg::TPM_OFS_MASK))
      next_mask = hwdata_i[2:0];
    if (start)
    begin
      if (eff_edge)
      begin
        next_reload = count;
        next_count = tpm_pkg::TPM_COUNT_RST;
        evt.edge_irq = first_seen;
        next_valid_res = first_seen;
        next_first_seen = 1'b1;
      end
      else if (cnt_step)
      begin
        next_count = count + 16'h0001;
        evt.ovf = (count == tpm_pkg::TPM_COUNT_MAX);
      end
    end
  end

  // Sticky status; set wins over clear
  always_comb
  begin
    next_stat = stat;
    if (irq_ack_i)
      next_stat[1:0] = 2'b00;
    if (wr && hit(req, tpm_pkg::TPM_OFS_STAT))
      next_stat[1:0] = stat[1:0] & ~hwdata_i[1:0];
    if (wr && hit(req, tpm_pkg::TPM_OFS_MODE) && start)
      next_stat[tpm_pkg::TPM_STAT_OVFLAG] = 1'b0;
    if (evt.edge_irq)
      next_stat[tpm_pkg::TPM_STAT_EDGE] = 1'b1;
    if (evt.ovf)
    begin
      next_stat[tpm_pkg::TPM_STAT_OVF] = 1'b1;
      next_stat[tpm_pkg::TPM_STAT_OVFLAG] = 1'b1;
    end
    next_irq = |(next_stat[1:0] & next_mask[1:0]);
  end

  // Read mux
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (next_req.valid && !next_req.write)
    begin
      case (next_req.addr)
        tpm_pkg::TPM_OFS_CTRL: next_rdata = {31'h0000_0000, next_start};
        tpm_pkg::TPM_OFS_MODE: next_rdata = {24'h00_0000, next_mode};
        tpm_pkg::TPM_OFS_TIMER: next_rdata = {16'h0000, next_reload};
        tpm_pkg::TPM_OFS_STAT: next_rdata = {29'h0000_0000, next_stat};
        tpm_pkg::TPM_OFS_MASK: next_rdata = {29'h0000_0000, next_mask};
        tpm_pkg::TPM_OFS_COUNT:
          next_rdata = {15'h0000, next_valid_res, next_count};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Registers only
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      req <= '0;
      start <= 1'b0;
      mode <= tpm_pkg::TPM_MODE_RST;
      count <= tpm_pkg::TPM_COUNT_RST;
      reload <= tpm_pkg::TPM_COUNT_RST;
      stat <= 3'h0;
      mask <= 3'h0;
      first_seen <= 1'b0;
      valid_res <= 1'b0;
      pin_d <= 1'b0;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      irq_o <= 1'b0;
      overflow_o <= 1'b0;
    end
    else
    begin
      req <= next_req;
      start <= next_start;
      mode <= next_mode;
      count <= next_count;
      reload <= next_reload;
      stat <= next_stat;
      mask <= next_mask;
      first_seen <= next_first_seen;
      valid_res <= next_valid_res;
      pin_d <= next_pin_d;
      hrdata_o <= next_rdata;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      irq_o <= next_irq;
      overflow_o <= next_stat[tpm_pkg::TPM_STAT_OVFLAG];
    end
  end

  chk_edge_restart: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    start && eff_edge |=> count == 16'h0000 && reload == $past(count))
    else $error("count not restarted at edge");
  chk_first_edge: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    start && eff_edge && !first_seen && !irq_ack_i |=> !stat[0] || $past(stat[0]))
    else $error("first edge raised a request");
  chk_ovf_flag: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    evt.ovf |=> stat[1] && stat[2] && overflow_o)
    else $error("overflow flag not set");
  chk_stop_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !start |=> $stable(count) && $stable(reload))
    else $error("counter moved while stopped");
  // flag clears only by mode write
  chk_flag_clear: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    stat[2] && !(wr && hit(req, tpm_pkg::TPM_OFS_MODE) && start) |=> stat[2])
    else $error("overflow flag lost");
  chk_bit_two: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !mode[tpm_pkg::TPM_MODE_BIT_TWO])
    else $error("mode bit two set");
  chk_ack_clear: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    irq_ack_i && !evt.edge_irq && !evt.ovf |=> stat[1:0] == 2'b00)
    else $error("acknowledge did not clear");
  chk_read_reload: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    next_req.valid && !next_req.write && next_req.addr == tpm_pkg::TPM_OFS_TIMER
    |=> hrdata_o[15:0] == reload)
    else $error("timer read not reload");
endmodule : tpm_core
`default_nettype wire

// [tpm_pulse_src.sv]
/*
  Pulse source for the timer's measure pin.
  Assumes hi/lo lengths only grow while run is high.
*/
`timescale 1ns/10ps
`default_nettype none
module tpm_pulse_src
(
  // Clock and control
  input wire logic mclk_i,
  input wire logic run_i,
  input wire logic [7:0] hi_i,
  input wire logic [7:0] lo_i,
  // Pulse out
  output logic pin_o
);
  logic [7:0] cnt;
  // High hi_i cycles, low lo_i; parked low when stopped
  always @(posedge mclk_i)
  begin
    if (!run_i)
    begin
      pin_o <= 1'b0;
      cnt <= 8'h00;
    end
    else if (cnt == (pin_o ? hi_i : lo_i) - 8'h01)
    begin
      pin_o <= !pin_o;
      cnt <= 8'h00;
    end
    else
      cnt <= cnt + 8'h01;
  end
endmodule : tpm_pulse_src
`default_nettype wire

// [timer_pulse_measurement_test.sv]
/*
  Self-checking bench for the pulse measurement timer.
  Assumes a zero-wait AHB-Lite slave and a pulse source model.
*/
`timescale 1ns/10ps
`default_nettype none
module timer_pulse_measurement_test;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic nbr = 1'b0;
  logic [4:0] fdiv = 5'h00;
  logic ack = 1'b0;
  logic irq;
  logic ovf;
  logic pin;
  logic run = 1'b0;
  logic [7:0] hi = 8'h0A;
  logic [7:0] lo = 8'h0A;
  logic [31:0] q;
  logic [31:0] t;
  int err_total = 0;
  int n_tests = 0;
  // Clock; fC32 level from a slow divider
  always #10 mclk = ~mclk;
  always @(posedge mclk) fdiv <= fdiv + 5'h01;
  tpm_core i_tpm_core (.mclk_i(mclk), .resetn_i(resetn), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .measure_input_pin_i(pin), .neighbour_channel_overflow_i(nbr),
    .fc32_i(fdiv[4]), .irq_ack_i(ack), .irq_o(irq), .overflow_o(ovf));
  tpm_pulse_src i_tpm_pulse_src (.mclk_i(mclk), .run_i(run), .hi_i(hi),
    .lo_i(lo), .pin_o(pin));
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask : end_sim
  task chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask : chk
  task rng(input logic [31:0] got, input logic [31:0] l, input logic [31:0] h);
  begin
    n_tests++;
    if ((got >= l && got <= h) !== 1'b1)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, l);
    end
  end
  endtask : rng
  // Wait for hready at an edge; read data taken there
  task hs;
  begin
    @(posedge mclk);
    while (hready !== 1'b1)
      @(posedge mclk);
    q = hrdata;
  end
  endtask : hs
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
  begin
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    hs();
    htrans <= 2'b00;
    hwdata <= d;
    hs();
  end
  endtask : bus
  // Wait for pin to leave v and return to it, then give capture time
  task wpin(input logic v);
    int k;
  begin
    k = 0;
    while (pin === v && k < 99)
    begin
      @(negedge mclk);
      k++;
    end
    while (pin !== v && k < 199)
    begin
      @(negedge mclk);
      k++;
    end
    chk(pin, v);
    repeat (4) @(posedge mclk);
  end
  endtask : wpin
  task pulse(input int n);
  begin
    repeat (n)
    begin
      nbr <= 1'b1;
      @(posedge mclk);
      nbr <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  end
  endtask : pulse
  task t_reset;
  begin
    bus(0, tpm_pkg::TPM_OFS_CTRL, 0);
    chk(q, 32'h0000_0000);
    bus(0, tpm_pkg::TPM_OFS_MODE, 0);
    chk(q, {24'h00_0000, tpm_pkg::TPM_MODE_RST});
    bus(0, tpm_pkg::TPM_OFS_STAT, 0);
    chk(q, 32'h0000_0000);
    bus(0, 8'h40, 0);
    chk(q, 32'h0000_0000);
    $display("reset test done");
  end
  endtask : t_reset
  task t_period;
  begin
    bus(1, tpm_pkg::TPM_OFS_CTRL, 1);
    bus(1, tpm_pkg::TPM_OFS_MASK, 1);
    run <= 1'b1;
    wpin(0);
    bus(0, tpm_pkg::TPM_OFS_STAT, 0);
    chk(q & 32'h0000_0001, 0);
    wpin(0);
    chk(irq, 1);
    bus(0, tpm_pkg::TPM_OFS_TIMER, 0);
    rng(q, 19, 21);
    bus(0, tpm_pkg::TPM_OFS_COUNT, 0);
    chk(q & 32'h0001_0000, 32'h0001_0000);
    ack <= 1'b1;
    @(posedge mclk);
    ack <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(irq, 0);
    wpin(0);
    bus(1, tpm_pkg::TPM_OFS_STAT, 1);
    bus(0, tpm_pkg::TPM_OFS_STAT, 0);
    chk(q & 32'h0000_0001, 0);
    run <= 1'b0;
    $display("period test done");
  end
  endtask : t_period
  task t_width;
  begin
    bus(1, tpm_pkg::TPM_OFS_MODE, 1);
    hi <= 8'h08;
    lo <= 8'h18;
    run <= 1'b1;
    wpin(0);
    bus(0, tpm_pkg::TPM_OFS_TIMER, 0);
    rng(q, 7, 9);
    wpin(1);
    bus(0, tpm_pkg::TPM_OFS_TIMER, 0);
    rng(q, 23, 25);
    run <= 1'b0;
    // Let the parking edge land before the hold test samples reload
    repeat (4) @(posedge mclk);
    $display("width test done");
  end
  endtask : t_width
  task t_hold;
  begin
    bus(0, tpm_pkg::TPM_OFS_TIMER, 0);
    t = q;
    bus(1, tpm_pkg::TPM_OFS_TIMER, 32'h0000_1234);
    bus(0, tpm_pkg::TPM_OFS_TIMER, 0);
    chk(q, t);
    bus(1, tpm_pkg::TPM_OFS_CTRL, 0);
    bus(0, tpm_pkg::TPM_OFS_COUNT, 0);
    t = q;
    repeat (20) @(posedge mclk);
    bus(0, tpm_pkg::TPM_OFS_COUNT, 0);
    chk(q, t);
    $display("hold test done");
  end
  endtask : t_hold
  task t_ovf;
    int k;
  begin
    bus(1, tpm_pkg::TPM_OFS_MODE, 0);
    bus(1, tpm_pkg::TPM_OFS_MASK, 2);
    bus(1, tpm_pkg::TPM_OFS_CTRL, 1);
    k = 0;
    while (ovf !== 1'b1 && k < 70000)
    begin
      @(posedge mclk);
      k++;
    end
    bus(0, tpm_pkg::TPM_OFS_STAT, 0);
    chk(q & 32'h0000_0006, 32'h0000_0006);
    chk(irq, 1);
    bus(1, tpm_pkg::TPM_OFS_STAT, 2);
    bus(1, tpm_pkg::TPM_OFS_CTRL, 0);
    bus(1, tpm_pkg::TPM_OFS_MODE, 0);
    bus(0, tpm_pkg::TPM_OFS_STAT, 0);
    chk(q & 32'h0000_0006, 32'h0000_0004);
    chk(irq, 0);
    bus(1, tpm_pkg::TPM_OFS_CTRL, 1);
    bus(1, tpm_pkg::TPM_OFS_MODE, 0);
    bus(0, tpm_pkg::TPM_OFS_STAT, 0);
    chk(q & 32'h0000_0004, 0);
    $display("overflow test done");
  end
  endtask : t_ovf
  task t_event;
  begin
    bus(1, tpm_pkg::TPM_OFS_MODE, 32'h0000_0022);
    bus(0, tpm_pkg::TPM_OFS_COUNT, 0);
    t = q;
    pulse(5);
    bus(0, tpm_pkg::TPM_OFS_COUNT, 0);
    chk(q & 32'h0000_FFFF, (t + 5) & 32'h0000_FFFF);
    bus(1, tpm_pkg::TPM_OFS_MODE, 32'h0000_0002);
    bus(0, tpm_pkg::TPM_OFS_COUNT, 0);
    t = q;
    pulse(3);
    bus(0, tpm_pkg::TPM_OFS_COUNT, 0);
    chk(q & 32'h0000_FFFF, t & 32'h0000_FFFF);
    bus(0, tpm_pkg::TPM_OFS_MODE, 0);
    chk(q & 32'h0000_0004, 0);
    $display("event test done");
  end
  endtask : t_event
  // Count clocks f8, f32 and fC32, then pin rising edges as events
  task t_clock;
  begin
    hi <= 8'h20;
    lo <= 8'h20;
    bus(1, tpm_pkg::TPM_OFS_MODE, 32'h0000_0040);
    run <= 1'b1;
    wpin(0);
    wpin(0);
    bus(0, tpm_pkg::TPM_OFS_TIMER, 0);
    rng(q, 7, 9);
    hi <= 8'h40;
    lo <= 8'h40;
    bus(1, tpm_pkg::TPM_OFS_MODE, 32'h0000_0080);
    wpin(0);
    wpin(0);
    bus(0, tpm_pkg::TPM_OFS_TIMER, 0);
    rng(q, 3, 5);
    bus(1, tpm_pkg::TPM_OFS_MODE, 32'h0000_00C0);
    wpin(0);
    wpin(0);
    bus(0, tpm_pkg::TPM_OFS_TIMER, 0);
    rng(q, 3, 5);
    bus(1, tpm_pkg::TPM_OFS_MODE, 32'h0000_000A);
    wpin(0);
    bus(0, tpm_pkg::TPM_OFS_COUNT, 0);
    t = q;
    wpin(1);
    bus(0, tpm_pkg::TPM_OFS_COUNT, 0);
    chk(q & 32'h0000_FFFF, (t + 1) & 32'h0000_FFFF);
    run <= 1'b0;
    $display("clock test done");
  end
  endtask : t_clock
  // Hang guard, above the overflow wait plus margin
  initial
  begin
    #1_800_000;
    err_total++;
    end_sim();
  end
  // Main sequence
  initial
  begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_period();
    t_width();
    t_hold();
    t_ovf();
    t_event();
    t_clock();
    end_sim();
  end
endmodule : timer_pulse_measurement_test
`default_nettype wire
